// file: hdl/nidr_pkg.sv
// package: offsets, reset values, field layout and carriers for the id bank
`default_nettype none
package nidr_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] NIDR_OFF_UID_UPPER = 8'h24;
    localparam logic [7:0] NIDR_OFF_UID_LOWER = 8'h28;
    localparam logic [7:0] NIDR_OFF_ROM_MAP = 8'h34;
    localparam logic [7:0] NIDR_OFF_FW_LOW = 8'h38;

    // ------------------------------------------------------------
    // reset values and fields
    // ------------------------------------------------------------
    localparam logic [31:0] NIDR_RST_UID = 32'h0000_0000;
    localparam logic [31:0] NIDR_RST_ROM_MAP = 32'h0000_0000;
    localparam int NIDR_ROM_BASE_LSB = 10;
    localparam logic [9:0] NIDR_ROM_RSVD_VAL = 10'h000;

    // ------------------------------------------------------------
    // configuration rom window on the 1394 side
    // ------------------------------------------------------------
    localparam logic [47:0] NIDR_ROM_WIN_LO = 48'hFFFF_F000_0400;
    localparam logic [47:0] NIDR_ROM_WIN_HI = 48'hFFFF_F000_07FF;

    // ------------------------------------------------------------
    // eeprom word indices
    // ------------------------------------------------------------
    localparam logic NIDR_EE_WORD_UPPER = 1'b0;
    localparam logic NIDR_EE_WORD_LOWER = 1'b1;

    typedef enum logic [1:0] {LD_START, LD_REQ_UP, LD_REQ_LO, LD_DONE}
        nidr_ld_state_t;

    // received quadlet read request from the link
    typedef struct packed {
        logic valid;
        logic [47:0] offset;
    } nidr_rom_rd_t;

    // host memory read issued for a mapped rom read
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
    } nidr_host_rd_t;

    // failed posted write report
    typedef struct packed {
        logic valid;
        logic [31:0] offset_low;
    } nidr_pw_fail_t;
endpackage : nidr_pkg
`default_nettype wire

// file: hdl/nidr_rom_mapper.sv
// module: maps configuration rom quadlet reads onto host memory
`default_nettype none
module nidr_rom_mapper
    import nidr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [31:0] rom_image_base,
    input wire nidr_rom_rd_t rom_rd,
    output nidr_host_rd_t host_rd
);
    // ------------------------------------------------------------
    // window decode
    // ------------------------------------------------------------
    wire logic in_window;
    wire logic [31:0] mapped_addr;
    nidr_host_rd_t host_rd_reg;
    nidr_host_rd_t host_rd_next;

    assign in_window = rom_rd.valid && (rom_rd.offset >= NIDR_ROM_WIN_LO)
        && (rom_rd.offset <= NIDR_ROM_WIN_HI);
    // base low bits are zero, so the add never carries into bit 10
    assign mapped_addr = rom_image_base
        + {22'h000000, rom_rd.offset[9:0]};
    assign host_rd_next = '{valid: in_window, addr: mapped_addr};
    assign host_rd = host_rd_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            host_rd_reg <= '0;
        else
            host_rd_reg <= host_rd_next;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_MAP_HIT: assert property (@(posedge pclk) disable iff (!presetn)
        in_window |=> host_rd.valid
            && host_rd.addr == $past(rom_image_base)
                + {22'h000000, $past(rom_rd.offset[9:0])})
        else $error("mapped rom read has wrong host address");
    AST_MAP_MISS: assert property (@(posedge pclk) disable iff (!presetn)
        (rom_rd.valid && (rom_rd.offset < NIDR_ROM_WIN_LO
            || rom_rd.offset > NIDR_ROM_WIN_HI)) |=> !host_rd.valid)
        else $error("read outside rom window was mapped");
    COV_MAP_HIT: cover property (@(posedge pclk) disable iff (!presetn)
        in_window ##1 host_rd.valid);
endmodule : nidr_rom_mapper
`default_nettype wire

// file: hdl/node_id_rom_map_regs.sv
// module: node unique id, rom mapping and failed write capture registers
`default_nettype none
// What this block does
// - hardware reset clears upper id quadlet to zero, an invalid id.
// - with eeprom present, load both id quadlets from it after reset.
// - upper id quadlet supplies bus info block third quadlet.
// - lower id quadlet at 28h, resets to zero, loads like upper.
// - rom window quadlet reads go to host at base plus low 10 bits.
// - rom map bits 31..10 read/write, bits 9..0 read zero.
// - failed posted write captures lower 32 offset bits.
// - capture register written only by hardware, undefined before first.
module node_id_rom_map_regs
    import nidr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ee_present,
    output logic ee_req,
    output logic ee_word,
    input wire logic ee_valid,
    input wire logic [31:0] ee_data,
    input wire nidr_rom_rd_t rom_rd,
    output nidr_host_rd_t host_rd,
    input wire nidr_pw_fail_t pw_fail,
    output logic [31:0] bib_quadlet3,
    output logic [31:0] uid_lower,
    output logic uid_loaded
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    nidr_ld_state_t ld_state_reg;
    nidr_ld_state_t ld_state_next;
    logic [31:0] uid_upper_reg;
    logic [31:0] uid_lower_reg;
    logic [31:0] rom_map_reg;
    logic [31:0] fw_low_reg;
    logic fw_seen_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic ee_req_reg;
    logic ee_word_reg;
    logic uid_loaded_reg;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire logic apb_setup;
    wire logic apb_access;
    wire logic apb_wr;
    wire logic hit_up;
    wire logic hit_lo;
    wire logic hit_map;
    wire logic hit_fw;
    wire logic hit_any;
    wire logic [31:0] rd_mux;

    // read data is latched at setup, so the access phase needs no wait
    assign apb_setup = psel && !penable;
    assign apb_access = psel && penable && pready_reg;
    assign apb_wr = apb_access && pwrite;
    assign hit_up = paddr == NIDR_OFF_UID_UPPER;
    assign hit_lo = paddr == NIDR_OFF_UID_LOWER;
    assign hit_map = paddr == NIDR_OFF_ROM_MAP;
    assign hit_fw = paddr == NIDR_OFF_FW_LOW;
    assign hit_any = hit_up || hit_lo || hit_map || hit_fw;
    assign rd_mux = hit_up ? uid_upper_reg :
        hit_lo ? uid_lower_reg :
        hit_map ? rom_map_reg :
        hit_fw ? fw_low_reg : 32'h0000_0000;

    // ------------------------------------------------------------
    // apb answer: one wait-free access phase after setup
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end
        else
        begin
            pready_reg <= apb_setup;
            pslverr_reg <= apb_setup && !hit_any;
            if (apb_setup && !pwrite)
                prdata_reg <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // rom mapping register
    // ------------------------------------------------------------
    // only the base field is stored; the reserved bits stay zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rom_map_reg <= NIDR_RST_ROM_MAP;
        else if (apb_wr && hit_map)
            rom_map_reg <= {pwdata[31:NIDR_ROM_BASE_LSB],
                NIDR_ROM_RSVD_VAL};
    end

    // ------------------------------------------------------------
    // unique id loader
    // ------------------------------------------------------------
    // strap is sampled in the first clocked state, never under reset
    always_comb
    begin
        ld_state_next = ld_state_reg;
        unique case (ld_state_reg)
            LD_START:
                ld_state_next = ee_present ? LD_REQ_UP : LD_DONE;
            LD_REQ_UP:
                if (ee_valid)
                    ld_state_next = LD_REQ_LO;
            LD_REQ_LO:
                if (ee_valid)
                    ld_state_next = LD_DONE;
            LD_DONE:
                ld_state_next = LD_DONE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ld_state_reg <= LD_START;
            ee_req_reg <= 1'b0;
            ee_word_reg <= NIDR_EE_WORD_UPPER;
            uid_loaded_reg <= 1'b0;
        end
        else
        begin
            ld_state_reg <= ld_state_next;
            // flopped so the flag turns on with the state, not after it
            uid_loaded_reg <= (ld_state_next == LD_DONE);
            ee_req_reg <= (ld_state_next == LD_REQ_UP)
                || (ld_state_next == LD_REQ_LO);
            ee_word_reg <= (ld_state_next == LD_REQ_LO) ?
                NIDR_EE_WORD_LOWER : NIDR_EE_WORD_UPPER;
        end
    end

    // no bus write path reaches the id quadlets
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            uid_upper_reg <= NIDR_RST_UID;
            uid_lower_reg <= NIDR_RST_UID;
        end
        else
        begin
            if (ld_state_reg == LD_REQ_UP && ee_valid)
                uid_upper_reg <= ee_data;
            if (ld_state_reg == LD_REQ_LO && ee_valid)
                uid_lower_reg <= ee_data;
        end
    end

    // ------------------------------------------------------------
    // failed posted write capture
    // ------------------------------------------------------------
    // data kept without reset: content is undefined until first capture
    always_ff @(posedge pclk)
    begin
        if (pw_fail.valid)
            fw_low_reg <= pw_fail.offset_low;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fw_seen_reg <= 1'b0;
        else if (pw_fail.valid)
            fw_seen_reg <= 1'b1;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    nidr_rom_mapper i_nidr_rom_mapper (
        .pclk(pclk),
        .presetn(presetn),
        .rom_image_base(rom_map_reg),
        .rom_rd(rom_rd),
        .host_rd(host_rd)
    );

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign ee_req = ee_req_reg;
    assign ee_word = ee_word_reg;
    assign bib_quadlet3 = uid_upper_reg;
    assign uid_lower = uid_lower_reg;
    // uid_loaded follows the loader reaching LD_DONE, also when the upper quadlet stays zero
    assign uid_loaded = uid_loaded_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_UID_RESET: assert property (
        (ld_state_reg == LD_START) |-> (uid_upper_reg == NIDR_RST_UID
            && uid_lower_reg == NIDR_RST_UID && !ee_req))
        else $error("id not zero before load");
    AST_LOAD_UPPER: assert property (
        (ld_state_reg == LD_REQ_UP && ee_valid) |=>
            uid_upper_reg == $past(ee_data) && ee_word == NIDR_EE_WORD_LOWER)
        else $error("upper id not loaded from eeprom");
    AST_NO_EEPROM: assert property (
        (ld_state_reg == LD_START && !ee_present) |=>
            (uid_loaded && !ee_req && uid_upper_reg == NIDR_RST_UID) [*2])
        else $error("load started without eeprom");
    AST_BIB_READ: assert property (
        (apb_setup && !pwrite && hit_up && !(ee_req && ee_valid)) |=>
            pready && prdata == bib_quadlet3 && !pslverr)
        else $error("upper id read differs from bus info quadlet");
    AST_LOAD_LOWER: assert property (
        (ld_state_reg == LD_REQ_LO && ee_valid) |=>
            uid_lower == $past(ee_data) && uid_loaded ##1 !ee_req)
        else $error("lower id not loaded from eeprom");
    AST_MAP_WRITE: assert property (
        (apb_wr && hit_map) |=> rom_map_reg[31:10] == $past(pwdata[31:10])
            && rom_map_reg[9:0] == NIDR_ROM_RSVD_VAL)
        else $error("rom map write wrong or reserved bits set");
    AST_FW_CAPTURE: assert property (
        pw_fail.valid |=> fw_low_reg == $past(pw_fail.offset_low))
        else $error("failed write offset not captured");
    AST_FW_HOLD: assert property (
        (fw_seen_reg && !pw_fail.valid) |=> $stable(fw_low_reg))
        else $error("capture register changed without event");
    AST_RO_WRITE: assert property (
        (apb_wr && (hit_up || hit_lo) && !ee_valid) |=>
            $stable(uid_upper_reg) && $stable(uid_lower_reg))
        else $error("software write changed id register");
    AST_UNMAPPED: assert property (
        (apb_setup && !hit_any) |=> pready && pslverr)
        else $error("unmapped access not flagged");
    AST_UNMAPPED_READ: assert property (
        (apb_setup && !pwrite && !hit_any) |=> prdata == 32'h0000_0000)
        else $error("unmapped read returned data");
    AST_MAPPED_OK: assert property (
        (apb_setup && hit_any) |=> pready && !pslverr)
        else $error("mapped access flagged as error");
    AST_READY_ONE: assert property (
        pready |=> !pready)
        else $error("ready stood for more than one cycle");
    AST_LO_READ: assert property (
        (apb_setup && !pwrite && hit_lo && !(ee_req && ee_valid)) |=>
            prdata == uid_lower)
        else $error("lower id read differs from register");
    AST_MAP_READ: assert property (
        (apb_setup && !pwrite && hit_map) |=>
            prdata[9:0] == NIDR_ROM_RSVD_VAL)
        else $error("rom map read shows reserved bits");
    AST_FW_READ: assert property (
        (apb_setup && !pwrite && hit_fw && fw_seen_reg) |=>
            prdata == $past(fw_low_reg))
        else $error("capture register read differs from capture");

    // ------------------------------------------------------------
    // checks: loader
    // ------------------------------------------------------------
    AST_WORD_UPPER: assert property (
        (ld_state_reg == LD_REQ_UP) |->
            (ee_req && ee_word == NIDR_EE_WORD_UPPER))
        else $error("upper word not requested first");
    AST_WORD_LOWER: assert property (
        (ld_state_reg == LD_REQ_LO) |->
            (ee_req && ee_word == NIDR_EE_WORD_LOWER))
        else $error("lower word not requested second");
    AST_REQ_END: assert property (
        $fell(ee_req) |-> uid_loaded)
        else $error("eeprom request dropped before both words");
    AST_ID_FROZEN: assert property (
        uid_loaded |=> uid_loaded && $stable(uid_upper_reg)
            && $stable(uid_lower_reg))
        else $error("id changed after load finished");

    // ------------------------------------------------------------
    // covers
    // ------------------------------------------------------------
    COV_NO_EE: cover property (
        (ld_state_reg == LD_START && !ee_present) ##1 uid_loaded);
    COV_EE_LOAD: cover property (
        (ld_state_reg == LD_REQ_UP) ##[1:20] uid_loaded);
    COV_FW_READ: cover property (
        pw_fail.valid ##[1:10] (apb_access && !pwrite && hit_fw));
    COV_MAP_RW: cover property (
        (apb_wr && hit_map) ##[1:10] (apb_access && !pwrite && hit_map));
endmodule : node_id_rom_map_regs
`default_nettype wire

// file: test/nidr_ee_model.sv
// eeprom reader model answering id word requests of the loader
`default_nettype none
module nidr_ee_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ee_req,
    input wire logic ee_word,
    input wire logic [31:0] word_upper,
    input wire logic [31:0] word_lower,
    input wire logic [3:0] dly,
    output logic ee_valid,
    output logic [31:0] ee_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ee_valid <= 1'b0;
            cnt <= 4'h0;
            ee_data <= 32'hFFFF_FFFF;
        end
        else
        begin
            ee_valid <= 1'b0;
            // released data never holds the last word
            if (ee_valid)
                ee_data <= ~ee_data;
            // skip the pulse cycle so one word is not answered twice
            else if (ee_req)
            begin
                if (cnt == dly)
                begin
                    ee_valid <= 1'b1;
                    ee_data <= ee_word ? word_lower : word_upper;
                    cnt <= 4'h0;
                end
                else
                    cnt <= cnt + 4'h1;
            end
        end
    end
endmodule : nidr_ee_model
`default_nettype wire

// file: test/tb_node_id_rom_map_regs.sv
// testbench for the node id, rom mapping and failed write registers
`default_nettype none
module tb_node_id_rom_map_regs
    import nidr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, ee_present = 1'b1;
    logic ee_req, ee_word, ee_valid, uid_loaded;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, ee_data, bib_quadlet3, uid_lower;
    logic [31:0] id_hi, id_lo, seed = 32'h0000_005F;
    nidr_rom_rd_t rom_rd = '0;
    nidr_pw_fail_t pw_fail = '0;
    nidr_host_rd_t host_rd;
    integer failures = 0, checked = 0;

    initial forever #50 pclk = ~pclk;

    node_id_rom_map_regs i_node_id_rom_map_regs (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ee_present(ee_present), .ee_req(ee_req),
        .ee_word(ee_word), .ee_valid(ee_valid), .ee_data(ee_data),
        .rom_rd(rom_rd), .host_rd(host_rd), .pw_fail(pw_fail),
        .bib_quadlet3(bib_quadlet3), .uid_lower(uid_lower),
        .uid_loaded(uid_loaded));
    nidr_ee_model i_nidr_ee_model (.pclk(pclk), .presetn(presetn),
        .ee_req(ee_req), .ee_word(ee_word), .word_upper(id_hi),
        .word_lower(id_lo), .dly(4'h3), .ee_valid(ee_valid),
        .ee_data(ee_data));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic give_verdict();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        integer n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            failures++;
            give_verdict();
        end
        else
        begin
            r = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    task automatic rom_cycle(input logic [47:0] off, input logic [31:0] b);
        logic hit;
        hit = off >= NIDR_ROM_WIN_LO && off <= NIDR_ROM_WIN_HI;
        @(posedge pclk);
        rom_rd <= {1'b1, off};
        @(posedge pclk);
        rom_rd <= '0;
        @(posedge pclk);
        chk({31'h0, host_rd.valid}, {31'h0, hit});
        if (hit)
            chk(host_rd.addr, b + {22'h0, off[9:0]});
    endtask : rom_cycle

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [31:0] r, base, x;
        logic e;
        logic [47:0] off;
        integer i;
        id_hi = xs();
        id_lo = xs();
        repeat (6) @(posedge pclk);
        chk(bib_quadlet3, NIDR_RST_UID);
        chk(uid_lower, NIDR_RST_UID);
        presetn <= 1'b1;
        for (i = 0; i < 100 && uid_loaded !== 1'b1; i++)
            @(posedge pclk);
        chk({31'h0, uid_loaded}, 32'h1);
        if (uid_loaded !== 1'b1)
            give_verdict();
        chk(bib_quadlet3, id_hi);
        chk(uid_lower, id_lo);
        apb(1'b0, NIDR_OFF_UID_UPPER, 32'h0, r, e);
        chk(r, id_hi);
        apb(1'b0, NIDR_OFF_UID_LOWER, 32'h0, r, e);
        chk(r, id_lo);
        apb(1'b0, NIDR_OFF_ROM_MAP, 32'h0, r, e);
        chk(r, NIDR_RST_ROM_MAP);
        // back to back captures, the last one must stick
        x = xs();
        @(posedge pclk);
        pw_fail <= {1'b1, xs()};
        @(posedge pclk);
        pw_fail <= {1'b1, x};
        @(posedge pclk);
        pw_fail <= '0;
        apb(1'b0, NIDR_OFF_FW_LOW, 32'h0, r, e);
        chk(r, x);
        apb(1'b1, NIDR_OFF_UID_UPPER, xs(), r, e);
        chk({31'h0, e}, 32'h0);
        apb(1'b1, NIDR_OFF_UID_LOWER, xs(), r, e);
        apb(1'b1, NIDR_OFF_FW_LOW, xs(), r, e);
        apb(1'b0, NIDR_OFF_FW_LOW, 32'h0, r, e);
        chk(r, x);
        apb(1'b0, NIDR_OFF_UID_UPPER, 32'h0, r, e);
        chk(r, id_hi);
        apb(1'b0, NIDR_OFF_UID_LOWER, 32'h0, r, e);
        chk(r, id_lo);
        apb(1'b1, 8'h3C, xs(), r, e);
        chk({31'h0, e}, 32'h1);
        apb(1'b0, 8'h3C, 32'h0, r, e);
        chk(r, 32'h0);
        chk({31'h0, e}, 32'h1);
        for (i = 0; i < 16; i++)
        begin
            base = xs();
            apb(1'b1, NIDR_OFF_ROM_MAP, base, r, e);
            apb(1'b0, NIDR_OFF_ROM_MAP, 32'h0, r, e);
            chk(r, base & 32'hFFFF_FC00);
            case (i)
                0: off = 48'hFFFF_F000_0400;
                1: off = 48'hFFFF_F000_07FF;
                2: off = 48'hFFFF_F000_03FF;
                3: off = 48'hFFFF_F000_0800;
                4: off = 48'hFFFF_F001_0400;
                default:
                begin
                    x = xs();
                    off = {36'hF_FFFF_0000, x[11:0]};
                end
            endcase
            rom_cycle(off, base & 32'hFFFF_FC00);
        end
        // second reset without eeprom: ids stay at the invalid value
        presetn <= 1'b0;
        ee_present <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({31'h0, uid_loaded}, 32'h1);
        chk({31'h0, ee_req}, 32'h0);
        chk(bib_quadlet3, NIDR_RST_UID);
        chk(uid_lower, NIDR_RST_UID);
        apb(1'b0, NIDR_OFF_UID_UPPER, 32'h0, r, e);
        chk(r, NIDR_RST_UID);
        apb(1'b0, NIDR_OFF_ROM_MAP, 32'h0, r, e);
        chk(r, NIDR_RST_ROM_MAP);
        give_verdict();
    end
endmodule : tb_node_id_rom_map_regs
`default_nettype wire
